//--- design/cpu_state.sv
// programmer-visible cpu state: pointers, accumulators, status word
//
// Operation
// RQ1: 16-bit instruction pointer addresses fetched instruction
// RQ2: 16-bit accumulator and temporary; bytes use low
// RQ3: index, extra and stack pointers, 16 bits
// RQ4: status word: bank pointer high, codes low
// RQ5: half carry from carry between bits 3-4
// RQ6: interrupts taken only while enable set; reset clears
// RQ7: level field gates requests; three blocks all
// RQ8: negative flag follows result top bit
// RQ9: zero flag set only for zero result
// RQ10: overflow flag tracks two's complement overflow
// RQ11: carry from bit 7, or shifted-out bit
// RQ12: banks of eight byte registers, 32 banks
// RQ13: 64K space: io low, data, program high
// RQ14: software places vector tables near top
// RQ15: bank base is data base plus bank*8
// RQ16: undefined flags keep their previous values
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps

module cpu_state #(
  parameter logic [15:0] DATA_AREA = cpu_state_pkg::DATA_BASE
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic fetch_advance,
  input wire logic irq_req,
  input wire logic [1:0] irq_req_level,
  output logic irq_take,
  output logic [15:0] instr_pointer,
  output logic [15:0] accumulator,
  output logic [15:0] temp_acc,
  output logic [15:0] index_reg,
  output logic [15:0] extra_pointer,
  output logic [15:0] stack_pointer,
  output logic [15:0] program_status_word,
  output logic [15:0] bank_base_addr,
  output logic [1:0] fetch_region
);

  // ***************************************************
  // helpers
  // ***************************************************

  // classify a 16-bit address within the 64K space
  function automatic logic [1:0] region_of(input logic [15:0] a);
    if (a < cpu_state_pkg::IO_TOP) begin
      region_of = 2'(cpu_state_pkg::REGION_IO);
    end else if (a < cpu_state_pkg::PROG_BASE) begin
      region_of = 2'(cpu_state_pkg::REGION_DATA);
    end else begin
      region_of = 2'(cpu_state_pkg::REGION_PROG);
    end
  endfunction : region_of

  // register bank base from the bank number, eight bytes per bank
  function automatic logic [15:0] bank_addr(input logic [4:0] bank);
    bank_addr = DATA_AREA + (16'(bank) << cpu_state_pkg::BANK_SHIFT);
  endfunction : bank_addr

  logic [7:0] alu_res;
  logic alu_h;
  logic alu_c;
  logic alu_v;
  logic alu_upd_nzc;
  logic alu_upd_hv;
  logic wr_ip;
  logic wr_acc;
  logic wr_psw;
  logic op_flags;
  logic [1:0] il_now;
  logic [4:0] bank_now;

  assign wr_ip = reg_wr && (reg_addr == cpu_state_pkg::OFS_IP);
  assign wr_acc = reg_wr && (reg_addr == cpu_state_pkg::OFS_ACC);
  assign wr_psw = reg_wr && (reg_addr == cpu_state_pkg::OFS_PSW);
  assign op_flags = op_valid && alu_upd_nzc;
  assign il_now = program_status_word[cpu_state_pkg::CC_IL1:
                                      cpu_state_pkg::CC_IL0];
  assign bank_now = program_status_word[cpu_state_pkg::BYTE_W +:
                                        cpu_state_pkg::BANK_BITS];

  // byte operations act on the low halves of both accumulators
  flag_alu u_alu (
    .op(op_code),
    .opa(accumulator[7:0]),
    .opb(temp_acc[7:0]),
    .res(alu_res),
    .half_c(alu_h),
    .carry(alu_c),
    .ovf(alu_v),
    .upd_nzc(alu_upd_nzc),
    .upd_hv(alu_upd_hv)
  );

  // ***************************************************
  // instruction pointer
  // ***************************************************

  // software load wins over a fetch step in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      instr_pointer <= cpu_state_pkg::WORD_ZERO;
    end else if (wr_ip) begin
      instr_pointer <= reg_wdata;
    end else if (fetch_advance) begin
      instr_pointer <= instr_pointer + cpu_state_pkg::IP_STEP; // [RQ1]
    end
  end

  // region of the fetch address, one cycle behind the pointer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fetch_region <= 2'(cpu_state_pkg::REGION_IO);
    end else begin
      fetch_region <= region_of(instr_pointer); // [RQ13]
    end
  end

  // ***************************************************
  // accumulators
  // ***************************************************

  // an operation beats a software write; the upper byte is untouched
  always_ff @(posedge core_clk) begin
    if (srst) begin
      accumulator <= cpu_state_pkg::WORD_ZERO;
    end else if (op_valid) begin
      accumulator[7:0] <= alu_res; // [RQ2]
    end else if (wr_acc) begin
      accumulator <= reg_wdata;
    end
  end

  // temporary accumulator is loaded only by software
  always_ff @(posedge core_clk) begin
    if (srst) begin
      temp_acc <= cpu_state_pkg::WORD_ZERO;
    end else if (reg_wr && (reg_addr == cpu_state_pkg::OFS_TMP)) begin
      temp_acc <= reg_wdata; // [RQ2]
    end
  end

  // ***************************************************
  // pointer registers
  // ***************************************************

  // index, extra and stack pointers are plain 16-bit storage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      index_reg <= cpu_state_pkg::WORD_ZERO;
      extra_pointer <= cpu_state_pkg::WORD_ZERO;
      stack_pointer <= cpu_state_pkg::WORD_ZERO;
    end else if (reg_wr) begin
      if (reg_addr == cpu_state_pkg::OFS_IX) begin
        index_reg <= reg_wdata; // [RQ3]
      end
      if (reg_addr == cpu_state_pkg::OFS_EP) begin
        extra_pointer <= reg_wdata; // [RQ3]
      end
      if (reg_addr == cpu_state_pkg::OFS_SP) begin
        stack_pointer <= reg_wdata; // [RQ3]
      end
    end
  end

  // ***************************************************
  // status word
  // ***************************************************

  // flag results from hardware win over a software write of the same
  // cycle, so no arithmetic outcome is lost; other bits take the write
  always_ff @(posedge core_clk) begin
    if (srst) begin
      program_status_word <= cpu_state_pkg::PSW_RESET; // [RQ6]
    end else begin
      if (wr_psw) begin
        program_status_word <= reg_wdata; // [RQ4]
      end
      if (op_flags) begin
        program_status_word[cpu_state_pkg::CC_N] <= alu_res[7]; // [RQ8]
        program_status_word[cpu_state_pkg::CC_Z] <=
          (alu_res == 8'h00); // [RQ9]
        program_status_word[cpu_state_pkg::CC_C] <= alu_c; // [RQ11]
        if (alu_upd_hv) begin
          program_status_word[cpu_state_pkg::CC_H] <= alu_h; // [RQ5]
          program_status_word[cpu_state_pkg::CC_V] <= alu_v; // [RQ10]
        end
      end
    end
  end

  // ***************************************************
  // register banks and interrupt gate
  // ***************************************************

  // low five bank pointer bits pick one of 32 banks of eight
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bank_base_addr <= DATA_AREA;
    end else begin
      bank_base_addr <=
        bank_addr(bank_now); // [RQ12] [RQ15]
    end
  end

  // a request needs enable set and strictly higher priority than field
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_take <= 1'b0;
    end else begin
      irq_take <= irq_req
        && program_status_word[cpu_state_pkg::CC_I] // [RQ6]
        && (il_now != cpu_state_pkg::IL_BLOCK)
        && (irq_req_level < il_now); // [RQ7]
    end
  end

  // ***************************************************
  // register read port
  // ***************************************************

  // data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (srst || !reg_rd) begin
      reg_rdata <= cpu_state_pkg::WORD_ZERO;
    end else begin
      unique case (reg_addr)
        cpu_state_pkg::OFS_IP: reg_rdata <= instr_pointer;
        cpu_state_pkg::OFS_ACC: reg_rdata <= accumulator;
        cpu_state_pkg::OFS_TMP: reg_rdata <= temp_acc;
        cpu_state_pkg::OFS_IX: reg_rdata <= index_reg;
        cpu_state_pkg::OFS_EP: reg_rdata <= extra_pointer;
        cpu_state_pkg::OFS_SP: reg_rdata <= stack_pointer;
        cpu_state_pkg::OFS_PSW: reg_rdata <= program_status_word; // [RQ4]
        default: reg_rdata <= cpu_state_pkg::WORD_ZERO;
      endcase
    end
  end

  // ***************************************************
  // checks
  // ***************************************************

  a_ip_step: assert property ( // [RQ1]
    @(posedge core_clk) disable iff (srst)
    (fetch_advance && !wr_ip) |=> instr_pointer == $past(instr_pointer)
      + cpu_state_pkg::IP_STEP)
    else $error("instruction pointer did not step");

  a_acc_upper_kept: assert property ( // [RQ2]
    @(posedge core_clk) disable iff (srst)
    op_valid |=> accumulator[15:8] == $past(accumulator[15:8]))
    else $error("byte operation touched accumulator upper byte");

  a_half_add: assert property ( // [RQ5]
    @(posedge core_clk) disable iff (srst)
    (op_valid && op_code == 3'(cpu_state_pkg::OP_ADD)) |=>
      program_status_word[cpu_state_pkg::CC_H] ==
      ((5'({1'b0, $past(accumulator[3:0])})
        + 5'({1'b0, $past(temp_acc[3:0])})) > 5'h0F))
    else $error("half carry wrong after add");

  a_reset_ie: assert property ( // [RQ6]
    @(posedge core_clk)
    srst |=> !program_status_word[cpu_state_pkg::CC_I])
    else $error("interrupt enable not cleared by reset");

  a_irq_disabled: assert property ( // [RQ6]
    @(posedge core_clk) disable iff (srst)
    !program_status_word[cpu_state_pkg::CC_I] |=> !irq_take)
    else $error("interrupt taken while disabled");

  a_irq_level_gate: assert property ( // [RQ7]
    @(posedge core_clk) disable iff (srst)
    (irq_req && program_status_word[cpu_state_pkg::CC_I]) |=>
      irq_take == ($past(il_now) != cpu_state_pkg::IL_BLOCK
        && $past(irq_req_level) < $past(il_now)))
    else $error("interrupt level gate wrong");

  a_neg_zero: assert property ( // [RQ8] [RQ9]
    @(posedge core_clk) disable iff (srst)
    op_flags |=> program_status_word[cpu_state_pkg::CC_N] == accumulator[7]
      && program_status_word[cpu_state_pkg::CC_Z] ==
      (accumulator[7:0] == 8'h00))
    else $error("negative or zero flag disagrees with result");

  a_ovf_sub: assert property ( // [RQ10]
    @(posedge core_clk) disable iff (srst)
    (op_valid && op_code == 3'(cpu_state_pkg::OP_SUB)) |=>
      program_status_word[cpu_state_pkg::CC_V] ==
      ($past(accumulator[7]) != $past(temp_acc[7])
        && accumulator[7] != $past(accumulator[7])))
    else $error("overflow wrong after subtract");

  a_carry_add: assert property ( // [RQ11]
    @(posedge core_clk) disable iff (srst)
    (op_valid && op_code == 3'(cpu_state_pkg::OP_ADD)) |=>
      program_status_word[cpu_state_pkg::CC_C] ==
      ((9'({1'b0, $past(accumulator[7:0])})
        + 9'({1'b0, $past(temp_acc[7:0])})) > 9'h0FF))
    else $error("carry wrong after add");

  a_bank_base: assert property ( // [RQ15]
    @(posedge core_clk) disable iff (srst)
    !$past(srst) |-> bank_base_addr == DATA_AREA
      + 16'($past(bank_now)) * (16'h0001 << cpu_state_pkg::BANK_SHIFT))
    else $error("bank base address wrong");

  a_flags_hold: assert property ( // [RQ16]
    @(posedge core_clk) disable iff (srst)
    (!op_flags && !wr_psw) |=> $stable(program_status_word))
    else $error("status word changed without cause");

  a_ptr_write: assert property ( // [RQ3]
    @(posedge core_clk) disable iff (srst)
    (reg_wr && reg_addr == cpu_state_pkg::OFS_SP) |=>
      stack_pointer == $past(reg_wdata))
    else $error("stack pointer write lost");

  a_psw_write: assert property ( // [RQ4]
    @(posedge core_clk) disable iff (srst)
    (wr_psw && !op_valid) |=> program_status_word == $past(reg_wdata))
    else $error("status word write lost");

  a_shift_carry: assert property ( // [RQ11]
    @(posedge core_clk) disable iff (srst)
    (op_valid && op_code == 3'(cpu_state_pkg::OP_SHL)) |=>
      program_status_word[cpu_state_pkg::CC_C] == $past(accumulator[7]))
    else $error("carry is not the bit shifted out");

  a_prog_region: assert property ( // [RQ13]
    @(posedge core_clk) disable iff (srst)
    (instr_pointer >= cpu_state_pkg::PROG_BASE) |=>
      fetch_region == 2'(cpu_state_pkg::REGION_PROG))
    else $error("fetch region wrong in program area");

  a_rdata_idle: assert property ( // [RQ4]
    @(posedge core_clk) disable iff (srst)
    !reg_rd |=> reg_rdata == cpu_state_pkg::WORD_ZERO)
    else $error("read data stood without a read");

endmodule : cpu_state

//--- design/cpu_state_pkg.sv
// constants and types shared by the cpu state block and its flag unit
package cpu_state_pkg;

  // ***************************************************
  // widths
  // ***************************************************
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned BANK_BITS = 5;
  localparam int unsigned BANK_SHIFT = 3;

  // ***************************************************
  // register indices on the plain register port
  // ***************************************************
  localparam logic [3:0] OFS_IP = 4'h0;
  localparam logic [3:0] OFS_ACC = 4'h1;
  localparam logic [3:0] OFS_TMP = 4'h2;
  localparam logic [3:0] OFS_IX = 4'h3;
  localparam logic [3:0] OFS_EP = 4'h4;
  localparam logic [3:0] OFS_SP = 4'h5;
  localparam logic [3:0] OFS_PSW = 4'h6;

  // ***************************************************
  // condition code byte layout (low byte of status word)
  // ***************************************************
  localparam int unsigned CC_C = 0;
  localparam int unsigned CC_V = 1;
  localparam int unsigned CC_Z = 2;
  localparam int unsigned CC_N = 3;
  localparam int unsigned CC_IL0 = 4;
  localparam int unsigned CC_IL1 = 5;
  localparam int unsigned CC_I = 6;
  localparam int unsigned CC_H = 7;

  // ***************************************************
  // reset values and fixed codes
  // ***************************************************
  localparam logic [15:0] PSW_RESET = 16'h0030;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] IP_STEP = 16'h0001;
  localparam logic [1:0] IL_BLOCK = 2'h3;

  // ***************************************************
  // memory map
  // ***************************************************
  localparam logic [15:0] IO_TOP = 16'h0080;
  localparam logic [15:0] DATA_BASE = 16'h0080;
  localparam logic [15:0] PROG_BASE = 16'h8000;

  typedef enum logic [2:0] {
    OP_ADD,
    OP_SUB,
    OP_SHL,
    OP_SHR,
    OP_LOAD
  } alu_op_e;

  typedef enum logic [1:0] {
    REGION_IO,
    REGION_DATA,
    REGION_PROG
  } mem_region_e;

endpackage : cpu_state_pkg

//--- design/flag_alu.sv
// 8-bit result and flag computation for the cpu state block
`timescale 1ns/100ps

module flag_alu (
  input wire logic [2:0] op,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  output logic [7:0] res,
  output logic half_c,
  output logic carry,
  output logic ovf,
  output logic upd_nzc,
  output logic upd_hv
);

  logic [8:0] wide;
  logic [4:0] nib;

  // one path per operation; shifts leave half carry and overflow alone
  always_comb begin
    wide = 9'h000;
    nib = 5'h00;
    res = opa;
    half_c = 1'b0;
    carry = 1'b0;
    ovf = 1'b0;
    upd_nzc = 1'b1;
    upd_hv = 1'b0;
    unique case (cpu_state_pkg::alu_op_e'(op))
      cpu_state_pkg::OP_ADD: begin
        wide = {1'b0, opa} + {1'b0, opb};
        nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
        res = wide[7:0];
        half_c = nib[4]; // [RQ5]
        carry = wide[8]; // [RQ11]
        ovf = (opa[7] == opb[7]) && (wide[7] != opa[7]); // [RQ10]
        upd_hv = 1'b1;
      end
      cpu_state_pkg::OP_SUB: begin
        wide = {1'b0, opa} - {1'b0, opb};
        nib = {1'b0, opa[3:0]} - {1'b0, opb[3:0]};
        res = wide[7:0];
        half_c = nib[4]; // borrow into bit 4 [RQ5]
        carry = wide[8]; // borrow out of bit 7 [RQ11]
        ovf = (opa[7] != opb[7]) && (wide[7] != opa[7]); // [RQ10]
        upd_hv = 1'b1;
      end
      cpu_state_pkg::OP_SHL: begin
        res = {opa[6:0], 1'b0};
        carry = opa[7]; // bit shifted out [RQ11]
      end
      cpu_state_pkg::OP_SHR: begin
        res = {1'b0, opa[7:1]};
        carry = opa[0]; // bit shifted out [RQ11]
      end
      cpu_state_pkg::OP_LOAD: begin
        res = opb;
        upd_nzc = 1'b0; // plain move defines no flag [RQ16]
      end
      default: begin
        upd_nzc = 1'b0;
      end
    endcase
  end

endmodule : flag_alu

//--- sim/cpu_state_tb_top.sv
// self-checking bench for the cpu state block
`timescale 1ns/100ps

module cpu_state_tb_top;
  // ***************************************************
  // stimulus and observed signals
  // ***************************************************
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic op_valid = 1'b0;
  logic [2:0] op_code = 3'h0;
  logic fetch_advance = 1'b0;
  logic irq_req = 1'b0;
  logic [1:0] irq_req_level = 2'h0;
  logic [15:0] reg_rdata, instr_pointer, accumulator, temp_acc, index_reg;
  logic [15:0] extra_pointer, stack_pointer, program_status_word;
  logic [15:0] bank_base_addr;
  logic [1:0] fetch_region;
  logic irq_take;
  int failures = 0;
  int checked = 0;
  int cycles = 0;

  cpu_state cpu_state_inst (
    .core_clk(core_clk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .op_valid(op_valid),
    .op_code(op_code),
    .fetch_advance(fetch_advance),
    .irq_req(irq_req),
    .irq_req_level(irq_req_level),
    .irq_take(irq_take),
    .instr_pointer(instr_pointer),
    .accumulator(accumulator),
    .temp_acc(temp_acc),
    .index_reg(index_reg),
    .extra_pointer(extra_pointer),
    .stack_pointer(stack_pointer),
    .program_status_word(program_status_word),
    .bank_base_addr(bank_base_addr),
    .fetch_region(fetch_region)
  );

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // ***************************************************
  // shared tasks
  // ***************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // hang guard, generous against the short sequence below
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // read data stands only in the cycle after the read edge
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
    @(posedge core_clk);
    #1;
    chk(reg_rdata, 16'h0000);
  endtask : rd

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic reset_values;
    chk(program_status_word, 16'h0030);
    chk(bank_base_addr, 16'h0080);
    chk({15'h0000, irq_take}, 16'h0000);
    chk(instr_pointer, 16'h0000);
  endtask : reset_values

  // every mapped index holds a full word; unmapped reads zero
  task automatic reg_map;
    logic [15:0] v;
    for (int i = 0; i < 7; i++) begin
      v = 16'hA5C0 + 16'(i) * 16'h1111;
      wr(4'(i), v);
      rd(4'(i), v);
    end
    wr(4'hA, 16'hFFFF);
    rd(4'hA, 16'h0000);
    chk(stack_pointer, 16'hA5C0 + 16'h5555);
    chk(instr_pointer, 16'hA5C0);
    chk(accumulator, 16'hB6D1);
    chk(temp_acc, 16'hC7E2);
    chk(index_reg, 16'hD8F3);
    chk(extra_pointer, 16'hEA04);
  endtask : reg_map

  // byte op on low bytes; high bytes must not leak in
  task automatic op_case(input logic [2:0] op, input logic [15:0] a,
      input logic [15:0] b, input logic [7:0] ps0, input logic [7:0] r,
      input logic [7:0] fl);
    wr(cpu_state_pkg::OFS_ACC, a);
    wr(cpu_state_pkg::OFS_TMP, b);
    wr(cpu_state_pkg::OFS_PSW, {8'h00, ps0});
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= op;
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
    chk(accumulator, {a[15:8], r});
    chk(program_status_word, {8'h00, fl});
  endtask : op_case

  task automatic flag_ops;
    op_case(3'h0, 16'h1280, 16'hFF80, 8'h30, 8'h00, 8'h37);
    op_case(3'h0, 16'h000F, 16'h0001, 8'h30, 8'h10, 8'hB0);
    op_case(3'h1, 16'h0000, 16'h0001, 8'h30, 8'hFF, 8'hB9);
    op_case(3'h1, 16'h0080, 16'h0001, 8'h30, 8'h7F, 8'hB2);
    op_case(3'h2, 16'h0081, 16'h0000, 8'hB2, 8'h02, 8'hB3);
    op_case(3'h3, 16'h0001, 16'h0000, 8'h30, 8'h00, 8'h35);
    op_case(3'h4, 16'h0055, 16'h00AA, 8'h3F, 8'hAA, 8'h3F);
    op_case(3'h5, 16'h0042, 16'h0011, 8'h3F, 8'h42, 8'h3F);
  endtask : flag_ops

  // rows: psw low byte, request, level, expected take (one hex digit each
  // for the last three); covers enable off, level 3, level 0, equal level
  task automatic irq_gate;
    logic [19:0] tbl [7];
    tbl = '{20'h20100, 20'h60111, 20'h60120, 20'h70100, 20'h50101,
      20'h40100, 20'h60000};
    for (int i = 0; i < 7; i++) begin
      wr(cpu_state_pkg::OFS_PSW, {8'h00, tbl[i][19:12]});
      @(posedge core_clk);
      irq_req <= tbl[i][8];
      irq_req_level <= tbl[i][5:4];
      @(posedge core_clk);
      #1;
      chk({15'h0000, irq_take}, {15'h0000, tbl[i][0]});
      @(posedge core_clk);
      irq_req <= 1'b0;
    end
  endtask : irq_gate

  // bank pointer sits in the high byte; base is data area plus bank*8
  task automatic bank_base;
    wr(cpu_state_pkg::OFS_PSW, 16'h1F30);
    @(posedge core_clk);
    #1;
    chk(bank_base_addr, 16'h0178);
    wr(cpu_state_pkg::OFS_PSW, 16'h0130);
    @(posedge core_clk);
    #1;
    chk(bank_base_addr, 16'h0088);
  endtask : bank_base

  // op and status write in one cycle: op flags win, other bits written
  task automatic collide;
    wr(cpu_state_pkg::OFS_ACC, 16'h0080);
    wr(cpu_state_pkg::OFS_TMP, 16'h0080);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= 3'h0;
    reg_wr <= 1'b1;
    reg_addr <= cpu_state_pkg::OFS_PSW;
    reg_wdata <= 16'h02F8;
    @(posedge core_clk);
    op_valid <= 1'b0;
    reg_wr <= 1'b0;
    #1;
    chk(program_status_word, 16'h0277);
    chk(accumulator, 16'h0000);
  endtask : collide

  task automatic fetch_step(input logic [15:0] ip, input logic [1:0] r0,
      input logic [1:0] r1);
    wr(cpu_state_pkg::OFS_IP, ip);
    @(posedge core_clk);
    #1;
    chk({14'h0000, fetch_region}, {14'h0000, r0});
    @(posedge core_clk);
    fetch_advance <= 1'b1;
    @(posedge core_clk);
    fetch_advance <= 1'b0;
    #1;
    chk(instr_pointer, ip + 16'h0001);
    @(posedge core_clk);
    #1;
    chk({14'h0000, fetch_region}, {14'h0000, r1});
  endtask : fetch_step

  // mid-run reset must drop the interrupt enable again
  task automatic second_reset;
    wr(cpu_state_pkg::OFS_PSW, 16'h0340);
    @(posedge core_clk);
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk(program_status_word, 16'h0030);
    reset_values();
  endtask : second_reset

  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    reset_values();
    reg_map();
    flag_ops();
    irq_gate();
    bank_base();
    fetch_step(16'h007F, 2'h0, 2'h1);
    fetch_step(16'h7FFF, 2'h1, 2'h2);
    fetch_step(16'hFFFE, 2'h2, 2'h2);
    collide();
    second_reset();
    give_verdict();
  end
endmodule : cpu_state_tb_top
